/* File: rtl/coolant_gauge.sv */
// Coolant temperature gauge control: needle, check-gauges lamp, chime,
// actuator sweep and the hard-wired fog lamp indicator.
// Assumes messages arrive from a bus receiver on sys_clk; ignition and fog
// feed are raw pins and are synchronised here.
`timescale 1ns/1ns
`default_nettype none

module coolant_gauge #(
  parameter int unsigned TIMEOUT_CYCLES = gauge_pkg::MSG_TIMEOUT_CYCLES,
  parameter int unsigned DWELL_CYCLES = gauge_pkg::SWEEP_DWELL_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Pins from the harness
  input wire logic ign_run_start,
  input wire logic fog_feed,
  // Temperature messages from the bus receiver
  input wire logic msg_valid,
  input wire logic [7:0] msg_temp,
  // Actuator test request
  input wire logic test_req,
  // Gauge outputs
  output logic gauge_supply,
  output logic [6:0] needle_pos,
  output logic check_gauges,
  output logic chime,
  output logic test_busy,
  output logic fog_lamp
);

  gauge_pkg::gauge_state_t state;
  gauge_pkg::gauge_state_t next_state;

  logic ign_s1;
  logic ign_on;
  logic ign_prev;
  logic fog_s1;
  logic fog_s2;
  logic chime_done;
  logic [2:0] step;
  logic [2:0] next_step;
  logic [6:0] next_needle;
  logic [6:0] rom_data;
  logic msg_lost;
  logic dwell_done;

  // Pin synchronisers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ign_s1 <= 1'b0;
      ign_on <= 1'b0;
      ign_prev <= 1'b0;
      fog_s1 <= 1'b0;
      fog_s2 <= 1'b0;
    end
    else
    begin
      ign_s1 <= ign_run_start;
      ign_on <= ign_s1;
      ign_prev <= ign_on;
      fog_s1 <= fog_feed;
      fog_s2 <= fog_s1;
    end
  end

  // Decode of the current state and of the message
  wire in_test = (state == gauge_pkg::ST_TEST);
  wire in_crit = (state == gauge_pkg::ST_CRIT);
  wire in_hot = (state == gauge_pkg::ST_HIGH) || in_crit;
  wire ign_rise = ign_on && !ign_prev;
  wire run = ign_on && !in_test;
  wire start_test = run && test_req;
  wire accept = run && msg_valid && !test_req;
  wire sweep_end = in_test && dwell_done && (step == gauge_pkg::SWEEP_LAST);
  wire step_adv = in_test && dwell_done;

  wire t_crit = (msg_temp >= gauge_pkg::TEMP_CRIT);
  wire t_crit_hold = in_crit && (msg_temp > gauge_pkg::TEMP_CRIT_EXIT);
  wire t_high = (msg_temp >= gauge_pkg::TEMP_HIGH);
  wire t_high_hold = in_hot && (msg_temp > gauge_pkg::TEMP_NORM_MAX);
  wire t_low = (msg_temp <= gauge_pkg::TEMP_LOW_MAX);

  // Scale mapping, 40 degC left stop to 125 degC right
  function automatic logic [6:0] lin_pos(input logic [7:0] t);
    logic [7:0] tc;
    logic [14:0] prod;
    logic [14:0] q;
    tc = (t > gauge_pkg::TEMP_SCALE_MAX) ? gauge_pkg::TEMP_SCALE_MAX : t;
    prod = 15'(tc - gauge_pkg::TEMP_SCALE_MIN) * gauge_pkg::SWEEP_SPAN;
    q = prod / gauge_pkg::TEMP_SPAN;
    return q[6:0];
  endfunction

  wire [6:0] msg_needle = lin_pos(msg_temp);

  // Next state
  always_comb
  begin
    next_state = state;
    if (!ign_on)
      next_state = gauge_pkg::ST_OFF;
    else if (start_test)
      next_state = gauge_pkg::ST_TEST;
    else if (in_test)
      next_state = sweep_end ? gauge_pkg::ST_WAIT : gauge_pkg::ST_TEST;
    else if (state == gauge_pkg::ST_OFF)
      next_state = gauge_pkg::ST_WAIT;
    else if (accept)
    begin
      if (t_crit)
        next_state = gauge_pkg::ST_CRIT;
      else if (t_crit_hold)
        next_state = gauge_pkg::ST_CRIT;
      else if (t_high)
        next_state = gauge_pkg::ST_HIGH;
      else if (t_high_hold)
        next_state = gauge_pkg::ST_HIGH;
      else if (t_low)
        next_state = gauge_pkg::ST_LOW;
      else
        next_state = gauge_pkg::ST_NORM;
    end
    else if (msg_lost)
      next_state = gauge_pkg::ST_WAIT;
  end

  // Next needle position
  always_comb
  begin
    case (next_state)
      gauge_pkg::ST_NORM:
        next_needle = accept ? msg_needle : needle_pos;
      gauge_pkg::ST_HIGH:
        next_needle = gauge_pkg::RED_CENTRE;
      gauge_pkg::ST_CRIT:
        next_needle = gauge_pkg::NEEDLE_MAX;
      gauge_pkg::ST_TEST:
        next_needle = rom_data;
      default:
        next_needle = gauge_pkg::NEEDLE_MIN;
    endcase
  end

  assign next_step = !in_test ? 3'h0 : (step_adv ? step + 3'h1 : step);

  wire next_hot = (next_state == gauge_pkg::ST_HIGH) ||
                  (next_state == gauge_pkg::ST_CRIT);
  wire next_chime = next_hot && !in_hot && !chime_done;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state <= gauge_pkg::ST_OFF;
      step <= 3'h0;
      needle_pos <= gauge_pkg::NEEDLE_MIN;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      needle_pos <= next_needle;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      check_gauges <= 1'b0;
      chime <= 1'b0;
      chime_done <= 1'b0;
      test_busy <= 1'b0;
      gauge_supply <= 1'b0;
      fog_lamp <= 1'b0;
    end
    else
    begin
      check_gauges <= next_hot;
      chime <= next_chime;
      chime_done <= ign_on && (chime_done || next_chime);
      test_busy <= (next_state == gauge_pkg::ST_TEST);
      // Supply only in On or Start
      gauge_supply <= ign_on;
      fog_lamp <= fog_s2;
    end
  end

  wire loss_restart = !ign_on || ign_rise || accept || in_test;

  gauge_timer #(
    .LIMIT(TIMEOUT_CYCLES)
  ) u_loss_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(loss_restart),
    .expired(msg_lost)
  );

  // Each sweep point dwells long enough for the air core to settle
  gauge_timer #(
    .LIMIT(DWELL_CYCLES)
  ) u_dwell_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .restart(!in_test || step_adv),
    .expired(dwell_done)
  );

  gauge_sweep_rom u_sweep_rom (
    .sys_clk(sys_clk),
    .addr(next_step),
    .data(rom_data)
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_test_entry;
    start_test;
  endsequence

  sequence s_hot_entry;
    accept && t_high && !in_hot;
  endsequence

  a_norm_linear: assert property (
    accept && !t_low && !t_high && !in_hot && !start_test
    |=> needle_pos == $past(msg_needle))
    else $error("needle not at linear position");

  a_norm_hold: assert property (
    state == gauge_pkg::ST_NORM && run && !msg_valid && !msg_lost
    && !test_req |=> $stable(needle_pos))
    else $error("linear position not held");

  a_low_left: assert property (
    accept && t_low |=> needle_pos == gauge_pkg::NEEDLE_MIN)
    else $error("low message did not pin needle left");

  a_high_centre: assert property (
    accept && t_high && !t_crit && !t_crit_hold
    |=> needle_pos == gauge_pkg::RED_CENTRE && check_gauges)
    else $error("high message not shown at red centre");

  a_chime_first: assert property (
    s_hot_entry ##0 !chime_done && ign_on |=> chime ##1 !chime)
    else $error("first hot entry did not chime once");

  a_chime_once: assert property (
    chime_done && ign_on |=> !chime)
    else $error("second chime in one ignition cycle");

  a_high_hold: assert property (
    accept && in_hot && !t_crit && !in_crit
    && msg_temp > gauge_pkg::TEMP_NORM_MAX
    |=> state == gauge_pkg::ST_HIGH && check_gauges)
    else $error("hot state dropped above exit point");

  a_crit_right: assert property (
    accept && t_crit |=> needle_pos == gauge_pkg::NEEDLE_MAX)
    else $error("critical message not at far right");

  a_crit_hold: assert property (
    accept && in_crit && msg_temp > gauge_pkg::TEMP_CRIT_EXIT
    |=> state == gauge_pkg::ST_CRIT)
    else $error("critical state dropped above exit point");

  a_loss_min: assert property (
    msg_lost && run && !msg_valid && !test_req
    |=> needle_pos == gauge_pkg::NEEDLE_MIN && !check_gauges)
    else $error("message loss did not drop needle");

  a_off_clear: assert property (
    !ign_on |=> needle_pos == gauge_pkg::NEEDLE_MIN && !check_gauges
    && state == gauge_pkg::ST_OFF)
    else $error("ignition off left state behind");

  a_test_first: assert property (
    s_test_entry |=> test_busy
    && needle_pos == gauge_pkg::SWEEP_POINTS[0])
    else $error("sweep did not start at first point");

  a_supply_ign: assert property (
    !ign_run_start [*3] |=> !gauge_supply)
    else $error("gauge supplied with ignition off");

  a_fog_follow: assert property (
    fog_lamp == $past(fog_feed, 3) || $past(sys_rst, 3))
    else $error("fog lamp does not follow feed");

  a_loss_restart: assert property (
    accept |=> !msg_lost)
    else $error("loss timer not restarted by message");

endmodule
`default_nettype wire

/* File: include/gauge_pkg.sv */
// Constants, state codes and timing for the coolant temperature gauge.
// Assumes a 10 MHz system clock and temperature messages in whole degC.
//
// How it works
// - Messages of 41 to 124 degC place the needle linearly on the scale.
// - The linear position holds until the next message, message loss, a test or off.
// - Messages at or below 40 degC pin the needle at the leftmost mark.
// - Messages of 127 degC or more: needle to red centre, warning lamp on.
// - Entering the hot state chimes once; one chime per ignition cycle.
// - Hot state holds needle and lamp until 124 degC or lower, or off.
// - Messages of 129 degC or more move the needle to the far right.
// - Critical state holds the far right until 127 degC or lower, or off.
// - No message for over twelve seconds drops the needle to minimum.
// - Ignition off returns the needle low and forgets every held state.
// - Actuator test sweeps the needle through fixed points in order.
// - The gauge is driven only with the ignition in On or Start.
// - Scale maps 40 to 125 degC onto a 90 degree needle sweep.
// - Fog lamp indicator follows its wired feed, not ignition or bus.

package gauge_pkg;

  // Clock and times
  localparam int unsigned CLK_HZ = 32'h0098_9680;
  localparam int unsigned MS_PER_S = 32'h3E8;
  localparam int unsigned CLK_PER_MS = CLK_HZ / MS_PER_S;
  localparam int unsigned MSG_TIMEOUT_MS = 32'h2EE0;
  localparam int unsigned MSG_TIMEOUT_CYCLES = MSG_TIMEOUT_MS * CLK_PER_MS;
  localparam int unsigned SWEEP_DWELL_MS = 32'h1F4;
  localparam int unsigned SWEEP_DWELL_CYCLES = SWEEP_DWELL_MS * CLK_PER_MS;

  // Temperature thresholds in degC
  localparam logic [7:0] TEMP_LOW_MAX = 8'h28;
  localparam logic [7:0] TEMP_SCALE_MIN = 8'h28;
  localparam logic [7:0] TEMP_SCALE_MAX = 8'h7D;
  localparam logic [7:0] TEMP_NORM_MAX = 8'h7C;
  localparam logic [7:0] TEMP_HIGH = 8'h7F;
  localparam logic [7:0] TEMP_CRIT_EXIT = 8'h7F;
  localparam logic [7:0] TEMP_CRIT = 8'h81;

  // Needle angle in degrees of sweep
  localparam logic [14:0] SWEEP_SPAN = 15'h5A;
  localparam logic [14:0] TEMP_SPAN = 15'h55;
  localparam logic [6:0] NEEDLE_MIN = 7'h00;
  localparam logic [6:0] NEEDLE_MAX = 7'h5A;
  localparam logic [6:0] RED_CENTRE = 7'h55;

  // Calibration sweep, entry 0 first
  localparam int unsigned SWEEP_N = 32'h6;
  localparam logic [2:0] SWEEP_LAST = 3'h5;
  localparam logic [5:0][6:0] SWEEP_POINTS =
    {7'h00, 7'h2D, 7'h5A, 7'h3C, 7'h1E, 7'h00};

  typedef enum logic [6:0] {
    ST_OFF  = 7'h01,
    ST_WAIT = 7'h02,
    ST_LOW  = 7'h04,
    ST_NORM = 7'h08,
    ST_HIGH = 7'h10,
    ST_CRIT = 7'h20,
    ST_TEST = 7'h40
  } gauge_state_t;

endpackage

/* File: rtl/gauge_timer.sv */
// Restartable interval counter that saturates at its limit.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module gauge_timer #(
  parameter int unsigned LIMIT = 32'h10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire logic restart,
  // Status
  output logic expired
);

  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  logic [W-1:0] count;
  wire at_limit = (count >= LIM);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || restart)
      count <= '0;
    else if (!at_limit)
      count <= count + 1'b1;
  end

  assign expired = at_limit;

endmodule
`default_nettype wire

/* File: rtl/gauge_sweep_rom.sv */
// Calibration point table for the actuator sweep, registered read.
// Assumes the address comes from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module gauge_sweep_rom (
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic [2:0] addr,
  output logic [6:0] data
);

  wire [6:0] point = (addr > gauge_pkg::SWEEP_LAST) ?
    gauge_pkg::NEEDLE_MIN : gauge_pkg::SWEEP_POINTS[addr];

  always_ff @(posedge sys_clk)
  begin
    data <= point;
  end

endmodule
`default_nettype wire

/* File: tb/engine_ctrl_model.sv */
// Engine controller stand-in: sends coolant temperature messages.
// Assumes the gauge takes a message on the edge where msg_valid is high.
`timescale 1ns/1ns
`default_nettype none

module engine_ctrl_model (
  // Clock
  input wire logic sys_clk,
  // Message bus towards the gauge
  output logic msg_valid,
  output logic [7:0] msg_temp
);
  initial
  begin
    msg_valid = 1'b0;
    msg_temp = 8'hA5;
  end

  task automatic send(input logic [7:0] temp, input int gap);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    msg_valid <= 1'b1;
    msg_temp <= temp;
    @(posedge sys_clk);
    msg_valid <= 1'b0;
    // Released byte shows junk, so stale data cannot pass for a message
    msg_temp <= ~temp;
  endtask
endmodule

`default_nettype wire

/* File: tb/tb_coolant_temp_gauge_control.sv */
// Self-checking bench for the coolant gauge control block.
// Assumes short timeout and dwell parameters; messages come from the model.
`timescale 1ns/1ns
`default_nettype none

module tb_coolant_temp_gauge_control;
  localparam int unsigned TMO = 50;
  typedef struct packed {logic [6:0] needle; logic lamp; logic chime;} note_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ign_run_start = 1'b0;
  logic fog_feed = 1'b0;
  logic test_req = 1'b0;
  wire logic msg_valid;
  wire logic [7:0] msg_temp;
  wire logic gauge_supply, check_gauges, chime, test_busy, fog_lamp;
  wire logic [6:0] needle_pos;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 41476;
  int st = 0;
  int fog_cnt = 0;
  logic used = 1'b0;
  logic pend = 1'b0;
  note_t notes[$];
  logic [6:0] got[$];
  logic [7:0] plain[8] = '{8'h28, 8'h29, 8'h52, 8'h7C, 8'h1E, 8'h00,
    8'h7D, 8'h7E};
  logic [7:0] hot[11] = '{8'h80, 8'h7E, 8'h7D, 8'h7C, 8'h7F, 8'h81, 8'h80,
    8'h7F, 8'hC8, 8'h7C, 8'h80};

  always #50 sys_clk = ~sys_clk;

  engine_ctrl_model eng (.sys_clk(sys_clk), .msg_valid(msg_valid),
    .msg_temp(msg_temp));

  coolant_gauge #(.TIMEOUT_CYCLES(TMO), .DWELL_CYCLES(4)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ign_run_start(ign_run_start),
    .fog_feed(fog_feed), .msg_valid(msg_valid), .msg_temp(msg_temp),
    .test_req(test_req), .gauge_supply(gauge_supply),
    .needle_pos(needle_pos), .check_gauges(check_gauges), .chime(chime),
    .test_busy(test_busy), .fog_lamp(fog_lamp));

  task automatic end_sim;
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic fail(input string m);
    num_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic check_gauge(input note_t e);
    n_tests++;
    if ({needle_pos, check_gauges, chime} !== e)
      fail($sformatf("gauge %h/%b/%b want %h/%b/%b", needle_pos,
        check_gauges, chime, e.needle, e.lamp, e.chime));
  endtask

  task automatic check_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask

  task automatic check_needle(input logic [6:0] e);
    n_tests++;
    if (needle_pos !== e)
      fail($sformatf("needle %h want %h", needle_pos, e));
  endtask

  // Works out the answer to one message, notes it, then sends it
  task automatic apply(input logic [7:0] t);
    note_t n;
    logic hot0;
    int v;
    n = '0;
    hot0 = (st >= 3);
    if (ign_run_start)
    begin
      if (t >= 8'h81 || (st == 4 && t > 8'h7F)) st = 4;
      else if (t >= 8'h7F || (hot0 && t > 8'h7C)) st = 3;
      else if (t <= 8'h28) st = 1;
      else st = 2;
      v = (t > 8'h7D) ? 125 : int'(t);
      n.needle = (st == 4) ? 7'h5A : (st == 3) ? 7'h55 : (st == 1) ? 7'h00 :
        7'((v - 40) * 90 / 85);
      n.lamp = (st >= 3);
      n.chime = n.lamp && !hot0 && !used;
      used = used | n.chime;
    end
    notes.push_back(n);
    eng.send(t, $unsigned($random(seed)) % 3);
  endtask

  always @(posedge sys_clk)
  begin
    pend <= msg_valid;
    fog_cnt <= fog_cnt + 1;
    if (fog_cnt % 8 == 7)
      fog_feed <= 1'($random(seed));
  end

  always @(negedge sys_clk)
  begin
    if (pend && notes.size() > 0)
      check_gauge(notes.pop_front());
    // Fog feed has been steady for six edges here; the synchronisers
    // still hold reset values for a few edges after release
    if (fog_cnt > 20 && fog_cnt % 8 == 6)
      check_bit(fog_lamp, fog_feed, "fog lamp");
  end

  initial
  begin
    #(100 * 20000);
    fail("timeout");
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ign_run_start <= 1'b1;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit(gauge_supply, 1'b1, "supply on");
    foreach (plain[i]) apply(plain[i]);
    repeat (20) apply(8'h29 + 8'($unsigned($random(seed)) % 84));
    foreach (hot[i]) apply(hot[i]);
    repeat (TMO - 8) @(posedge sys_clk);
    @(negedge sys_clk);
    check_needle(7'h55);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check_needle(7'h00);
    check_bit(check_gauges, 1'b0, "lamp after loss");
    st = 0;
    apply(8'h64);
    // A timer left expired would drop the needle one edge later
    repeat (TMO - 8) @(posedge sys_clk);
    @(negedge sys_clk);
    check_needle(7'h3F);
    ign_run_start <= 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check_bit(gauge_supply, 1'b0, "supply off");
    check_bit(check_gauges, 1'b0, "lamp off");
    check_needle(7'h00);
    apply(8'h80);
    st = 0;
    used = 1'b0;
    ign_run_start <= 1'b1;
    repeat (5) @(posedge sys_clk);
    apply(8'h80);
    @(posedge sys_clk);
    test_req <= 1'b1;
    @(posedge sys_clk);
    test_req <= 1'b0;
    for (int k = 0; k < 10 && test_busy !== 1'b1; k++)
      @(negedge sys_clk);
    got.push_back(needle_pos);
    for (int k = 0; k < 100 && test_busy === 1'b1; k++)
    begin
      @(negedge sys_clk);
      if (test_busy === 1'b1 && needle_pos !== got[$])
        got.push_back(needle_pos);
    end
    check_bit(got.size() == 6, 1'b1, "sweep point count");
    foreach (got[i])
      check_bit(got[i] === gauge_pkg::SWEEP_POINTS[i], 1'b1, "sweep");
    check_needle(7'h00);
    st = 0;
    apply(8'h30);
    repeat (4) @(posedge sys_clk);
    end_sim();
  end
endmodule

`default_nettype wire
